// ==== hw/rtc_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_ctrl_params.svh"
module rtc_ctrl
  import rtc_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  // avalon-mm slave, byte address
  input wire logic [21:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // counting chain, same clock
  input wire logic i_half_tick,
  input wire logic i_sec_tick,
  input wire logic [6:0] i_sec,
  input wire logic [6:0] i_min,
  input wire logic [5:0] i_day,
  input wire logic i_hour_load,
  input wire logic [5:0] i_hour_next,
  input wire logic i_one_hz_src,
  input wire logic i_fast_clk_src,
  // control outputs
  output logic o_counter_run,
  output logic o_count_hold_request,
  output logic o_hour_format_sel,
  output logic [5:0] o_hour,
  output logic o_one_hz_pin,
  output logic o_fast_clock_pin,
  output logic o_alt_clk_out_en,
  output logic o_periodic_irq,
  output logic o_irq
);
  logic [7:0] ctrl0_q;
  logic hold_q;
  logic alt_en_q;
  logic flag_q;
  logic irq_en_q;
  logic [5:0] hour_q;
  logic wait_q;
  logic event_w;
  logic access;
  logic wr_go;
  logic [19:0] idx;
  logic wr_c0;
  logic wr_c1;
  logic wr_st;
  logic wr_ie;
  logic wr_hr;
  logic fmt_change;
  logic [7:0] rd_d;

  // bcd helpers shared by both conversions
  function automatic logic [4:0] bcd2bin(input logic [5:0] b);
    bcd2bin = 5'(b[5:4] * 4'd10 + b[3:0]);
  endfunction

  function automatic logic [5:0] bin2bcd(input logic [4:0] v);
    logic [4:0] tens;
    tens = (v >= 5'd20) ? 5'd2 : ((v >= 5'd10) ? 5'd1 : 5'd0);
    bin2bcd = {tens[1:0], 4'(v - 5'(tens * 5'd10))};
  endfunction

  // 24-hour bcd to 12-hour bcd with pm in bit 5
  function automatic logic [5:0] to_12h(input logic [5:0] h24);
    logic [4:0] h;
    h = bcd2bin(h24);
    if (h == 5'd0) begin
      to_12h = 6'h12;
    end else if (h < 5'd12) begin
      to_12h = bin2bcd(h);
    end else if (h == 5'd12) begin
      to_12h = 6'h32;
    end else begin
      to_12h = bin2bcd(5'(h - 5'd12)) | 6'h20;
    end
  endfunction

  // 12-hour bcd with pm bit to 24-hour bcd
  function automatic logic [5:0] to_24h(input logic [5:0] h12);
    logic [4:0] h;
    h = bcd2bin({1'b0, h12[4:0]});
    if (h == 5'd12) begin
      to_24h = h12[5] ? 6'h12 : 6'h00;
    end else begin
      to_24h = bin2bcd(h12[5] ? 5'(h + 5'd12) : h);
    end
  endfunction

  // address decode; low two address bits ignored, word-aligned
  assign idx = i_address[21:2];
  assign access = (i_read || i_write) && wait_q;
  assign wr_go = i_write && !wait_q && i_byteenable[0];
  assign wr_c0 = wr_go && (idx == `RTC_CTRL0_IDX);
  assign wr_c1 = wr_go && (idx == `RTC_CTRL1_IDX);
  assign wr_st = wr_go && (idx == `RTC_STATUS_IDX);
  assign wr_ie = wr_go && (idx == `RTC_IRQ_EN_IDX);
  assign wr_hr = wr_go && (idx == `RTC_HOUR_IDX);
  assign fmt_change = wr_c0 && (i_writedata[`RTC_FMT_BIT] != ctrl0_q[`RTC_FMT_BIT]);

  // one wait cycle per access, then the answer edge
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_q <= `RTC_WAIT_RST;
    end else begin
      wait_q <= !access;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (idx)
      `RTC_CTRL0_IDX: rd_d = ctrl0_q & ~(8'h01 << `RTC_ZERO_BIT);
      `RTC_CTRL1_IDX: rd_d = {6'h00, alt_en_q, hold_q};
      `RTC_STATUS_IDX: rd_d = {7'h00, flag_q};
      `RTC_IRQ_EN_IDX: rd_d = {7'h00, irq_en_q};
      `RTC_HOUR_IDX: rd_d = {2'h0, hour_q};
      default: rd_d = 8'h00;
    endcase
  end

  // read data loaded in the wait cycle so it stands at the answer edge
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_readdata <= 32'h00000000;
    end else if (access && i_read) begin
      o_readdata <= {24'h000000, rd_d};
    end
  end

  // control0; bit 6 never stored
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl0_q <= `RTC_CTRL0_RST;
    end else if (wr_c0) begin
      ctrl0_q <= i_writedata[7:0] & ~(8'h01 << `RTC_ZERO_BIT);
    end
  end

  // control1: hold request and alternate clock output enable
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_q <= 1'b0;
      alt_en_q <= 1'b0;
    end else if (wr_c1) begin
      hold_q <= i_writedata[`RTC_HOLD_BIT];
      alt_en_q <= i_writedata[`RTC_ALT_BIT];
    end
  end

  // hour register; format change wins over a chain load in the same cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hour_q <= `RTC_HOUR_RST;
    end else if (fmt_change) begin
      hour_q <= i_writedata[`RTC_FMT_BIT] ? to_24h(hour_q) : to_12h(hour_q);
    end else if (wr_hr) begin
      hour_q <= i_writedata[5:0];
    end else if (i_hour_load && ctrl0_q[`RTC_RUN_BIT]) begin
      hour_q <= i_hour_next;
    end
  end

  // periodic event source
  rtc_period_event u_event (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_sel(period_sel_t'(ctrl0_q[2:0])),
    .i_run(ctrl0_q[`RTC_RUN_BIT]),
    .i_fmt24(ctrl0_q[`RTC_FMT_BIT]),
    .i_half_tick(i_half_tick),
    .i_sec_tick(i_sec_tick),
    .i_sec(i_sec),
    .i_min(i_min),
    .i_hour(hour_q),
    .i_day(i_day),
    .o_event(event_w)
  );

  // sticky flag, write one to clear; a new event beats the clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_q <= 1'b0;
    end else if (event_w) begin
      flag_q <= 1'b1;
    end else if (wr_st && i_writedata[`RTC_PFLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  // interrupt enable, 1 lets the flag through
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_en_q <= 1'b0;
    end else if (wr_ie) begin
      irq_en_q <= i_writedata[`RTC_PFLAG_BIT];
    end
  end

  // level irq rises with the flag, falls one cycle after the flag clears
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
      o_periodic_irq <= 1'b0;
    end else begin
      o_irq <= (flag_q || event_w) && irq_en_q;
      o_periodic_irq <= event_w;
    end
  end

  // gated clock outputs; enable toggles mid-cycle can glitch, so change them stopped
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_one_hz_pin <= 1'b0;
      o_fast_clock_pin <= 1'b0;
    end else begin
      o_one_hz_pin <= ctrl0_q[`RTC_ONE_HZ_BIT] && i_one_hz_src;
      o_fast_clock_pin <= ctrl0_q[`RTC_FAST_BIT] && i_fast_clk_src;
    end
  end

  // control levels to the counting chain
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_counter_run <= 1'b0;
      o_count_hold_request <= 1'b0;
      o_hour_format_sel <= 1'b0;
      o_alt_clk_out_en <= 1'b0;
      o_hour <= `RTC_HOUR_RST;
    end else begin
      o_counter_run <= ctrl0_q[`RTC_RUN_BIT];
      o_count_hold_request <= hold_q;
      o_hour_format_sel <= ctrl0_q[`RTC_FMT_BIT];
      o_alt_clk_out_en <= alt_en_q;
      o_hour <= hour_q;
    end
  end

  // bus handshake, register copies and event bookkeeping
  wait_answer_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    access |=> !o_waitrequest)
    else $error("access not answered after one wait");
  wait_one_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!o_waitrequest) |=> o_waitrequest)
    else $error("waitrequest low twice");
  run_follow_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_c0 |=> ##1 (o_counter_run == $past(i_writedata[`RTC_RUN_BIT], 2)))
    else $error("run output not following write");
  hour_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!ctrl0_q[`RTC_RUN_BIT] && !fmt_change && !wr_hr) |=> $stable(hour_q))
    else $error("hour moved while counter stopped");
  one_hz_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !ctrl0_q[`RTC_ONE_HZ_BIT] |=> !o_one_hz_pin)
    else $error("1 Hz pin active while disabled");
  one_hz_on_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (ctrl0_q[`RTC_ONE_HZ_BIT] && i_one_hz_src) |=> o_one_hz_pin)
    else $error("1 Hz pin silent while enabled");
  fast_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !ctrl0_q[`RTC_FAST_BIT] |=> !o_fast_clock_pin)
    else $error("fast clock pin active while disabled");
  fast_on_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (ctrl0_q[`RTC_FAST_BIT] && i_fast_clk_src) |=> o_fast_clock_pin)
    else $error("fast clock pin silent while enabled");
  fmt_out_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_hour_format_sel == $past(ctrl0_q[`RTC_FMT_BIT]))
    else $error("format output mismatch");
  hold_out_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_count_hold_request == $past(hold_q))
    else $error("hold request output mismatch");
  to12_conv_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (fmt_change && !i_writedata[`RTC_FMT_BIT] && hour_q == 6'h13) |=> hour_q == 6'h21)
    else $error("13h not converted to 1 pm");
  to24_conv_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (fmt_change && i_writedata[`RTC_FMT_BIT] && hour_q == 6'h12) |=> hour_q == 6'h00)
    else $error("12 am not converted to 00");
  zero_bit_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !ctrl0_q[`RTC_ZERO_BIT])
    else $error("bit 6 stored");
  rd_zero_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (access && i_read && idx == `RTC_CTRL0_IDX) |=> !o_readdata[`RTC_ZERO_BIT])
    else $error("bit 6 read as one");
  flag_set_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    event_w |=> flag_q && o_periodic_irq)
    else $error("event lost");
  flag_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (wr_st && i_writedata[`RTC_PFLAG_BIT] && !event_w) |=> !flag_q)
    else $error("flag not cleared by write one");
  irq_level_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (flag_q && irq_en_q) |=> o_irq)
    else $error("irq not raised");
  irq_masked_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !irq_en_q |=> !o_irq)
    else $error("irq raised while masked");

  // wait mirrors wait_q directly
  assign o_waitrequest = wait_q;

  write_cov: cover property (@(posedge i_clk) disable iff (!i_nrst) wr_c0 ##2 o_counter_run);
  conv_cov: cover property (@(posedge i_clk) disable iff (!i_nrst) fmt_change);
  clear_race_cov: cover property (@(posedge i_clk) disable iff (!i_nrst)
    event_w && wr_st && i_writedata[0]);
endmodule
`default_nettype wire

// ==== hw/rtc_ctrl_params.svh ====
// What this block does
// - run bit 7 of control0 stops counting at 0, counts at 1.
// - 1 Hz pin driven only while its enable bit 5 is 1.
// - 32.768 kHz pin driven only while its enable bit 4 is 1.
// - format select 0 keeps 12-hour with am/pm, 1 keeps 24-hour.
// - a format change converts the hour register to the new system.
// - selector 000 none, 001 every 0.5 s, 010 every second increment.
// - 011 each minute, 100 each hour, 101 each day at zero time.
// - 110 and 111 fire monthly at day 1, midnight.
`ifndef RTC_CTRL_PARAMS_SVH
`define RTC_CTRL_PARAMS_SVH
// register indices; byte address is four times the index
`define RTC_CTRL0_IDX 20'hFFF9D
`define RTC_CTRL1_IDX 20'h00000
`define RTC_STATUS_IDX 20'h00001
`define RTC_IRQ_EN_IDX 20'h00002
`define RTC_HOUR_IDX 20'h00003
// control0 fields
`define RTC_RUN_BIT 7
`define RTC_ZERO_BIT 6
`define RTC_ONE_HZ_BIT 5
`define RTC_FAST_BIT 4
`define RTC_FMT_BIT 3
`define RTC_SEL_LSB 0
// control1 fields
`define RTC_HOLD_BIT 0
`define RTC_ALT_BIT 1
// status and irq enable fields
`define RTC_PFLAG_BIT 0
// reset values
`define RTC_CTRL0_RST 8'h00
`define RTC_HOUR_RST 6'h00
`define RTC_WAIT_RST 1'b1
`endif

// ==== hw/rtc_ctrl_pkg.sv ====
package rtc_ctrl_pkg;
  // constant-period selector encodings
  typedef enum logic [2:0] {
    PSEL_NONE = 3'h0,
    PSEL_HALF = 3'h1,
    PSEL_SEC = 3'h2,
    PSEL_MIN = 3'h3,
    PSEL_HOUR = 3'h4,
    PSEL_DAY = 3'h5,
    PSEL_MON_A = 3'h6,
    PSEL_MON_B = 3'h7
  } period_sel_t;
endpackage

// ==== hw/rtc_period_event.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_ctrl_params.svh"
module rtc_period_event
  import rtc_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire period_sel_t i_sel,
  input wire logic i_run,
  input wire logic i_fmt24,
  input wire logic i_half_tick,
  input wire logic i_sec_tick,
  input wire logic [6:0] i_sec,
  input wire logic [6:0] i_min,
  input wire logic [5:0] i_hour,
  input wire logic [5:0] i_day,
  output logic o_event
);
  logic at_min;
  logic at_hour;
  logic at_day;
  logic at_mon;
  logic hit;

  // zero-time matches; midnight reads 12 am in 12-hour form
  assign at_min = i_sec_tick && (i_sec == 7'h00);
  assign at_hour = at_min && (i_min == 7'h00);
  assign at_day = at_hour && (i_hour == (i_fmt24 ? 6'h00 : 6'h12));
  assign at_mon = at_day && (i_day == 6'h01);

  // event select
  always_comb begin
    case (i_sel)
      PSEL_NONE: hit = 1'b0;
      PSEL_HALF: hit = i_half_tick;
      PSEL_SEC: hit = i_sec_tick;
      PSEL_MIN: hit = at_min;
      PSEL_HOUR: hit = at_hour;
      PSEL_DAY: hit = at_day;
      PSEL_MON_A, PSEL_MON_B: hit = at_mon;
      default: hit = 1'b0;
    endcase
  end

  // a stopped counter produces no ticks worth reporting
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_event <= 1'b0;
    end else begin
      o_event <= hit && i_run;
    end
  end

  none_sel_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sel == PSEL_NONE) |=> !o_event) else $error("event with selector none");
  sec_event_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sel == PSEL_SEC && i_run && i_sec_tick) |=> o_event)
    else $error("second event missed");
  minute_event_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sel == PSEL_MIN && i_run && i_sec_tick && i_sec != 7'h00) |=> !o_event)
    else $error("minute event off second zero");
  month_event_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sel[2:1] == 2'b11 && i_run && i_sec_tick && i_sec == 7'h00 && i_min == 7'h00
     && i_hour == (i_fmt24 ? 6'h00 : 6'h12) && i_day == 6'h01) |=> o_event)
    else $error("month event missed");
  month_cov: cover property (@(posedge i_clk) disable iff (!i_nrst)
    i_sel == PSEL_MON_B ##1 o_event);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  import rtc_ctrl_pkg::*;
  localparam logic [21:0] A_C0 = 22'h3FFE74;
  localparam logic [21:0] A_C1 = 22'h000000;
  localparam logic [21:0] A_ST = 22'h000004;
  localparam logic [21:0] A_EN = 22'h000008;
  localparam logic [21:0] A_HR = 22'h00000C;
  localparam logic [21:0] A_BAD = 22'h000040;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_read = 1'b0, i_write = 1'b0;
  logic [21:0] i_address = '0;
  logic [3:0] i_byteenable = 4'hF;
  logic [31:0] i_writedata = '0, o_readdata;
  logic o_waitrequest, i_half_tick = 1'b0, i_sec_tick = 1'b0, i_hour_load = 1'b0;
  logic [6:0] i_sec = '0, i_min = '0;
  logic [5:0] i_day = 6'h01, i_hour_next = '0, o_hour;
  logic i_one_hz_src = 1'b0, i_fast_clk_src = 1'b0;
  logic o_counter_run, o_count_hold_request, o_hour_format_sel, o_one_hz_pin;
  logic o_fast_clock_pin, o_alt_clk_out_en, o_periodic_irq, o_irq;
  int errors = 0, total_checks = 0, cycles = 0, pulses = 0;
  logic [31:0] q;
  rtc_ctrl dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_byteenable(i_byteenable), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_half_tick(i_half_tick),
    .i_sec_tick(i_sec_tick), .i_sec(i_sec), .i_min(i_min), .i_day(i_day),
    .i_hour_load(i_hour_load), .i_hour_next(i_hour_next), .i_one_hz_src(i_one_hz_src),
    .i_fast_clk_src(i_fast_clk_src), .o_counter_run(o_counter_run),
    .o_count_hold_request(o_count_hold_request), .o_hour_format_sel(o_hour_format_sel),
    .o_hour(o_hour), .o_one_hz_pin(o_one_hz_pin), .o_fast_clock_pin(o_fast_clock_pin),
    .o_alt_clk_out_en(o_alt_clk_out_en), .o_periodic_irq(o_periodic_irq), .o_irq(o_irq));
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  // hang guard; the whole run needs under a thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (o_periodic_irq === 1'b1) pulses++;
    if (cycles > 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [21:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] r);
    @(posedge i_clk);
    i_address <= a;
    i_write <= wr;
    i_read <= ~wr;
    i_writedata <= d;
    i_byteenable <= be;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    r = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask
  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, {24'h000000, d}, 4'hF, r);
  endtask
  task automatic rd_chk(input string n, input logic [21:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h00000000, 4'hF, q);
    `CHK(n, {24'h000000, e}, q)
  endtask
  // enables set while stopped so the pins never glitch
  task automatic pins(input logic [7:0] c, input logic e1, input logic ef);
    wr(A_C0, c);
    rd_chk("ctrl0", A_C0, c & 8'hBF);
    i_one_hz_src <= 1'b1;
    i_fast_clk_src <= 1'b1;
    repeat (3) @(posedge i_clk);
    `CHK("one_hz_pin", e1, o_one_hz_pin)
    `CHK("fast_pin", ef, o_fast_clock_pin)
    i_one_hz_src <= 1'b0;
    i_fast_clk_src <= 1'b0;
    repeat (3) @(posedge i_clk);
    `CHK("pins_low", 2'b00, {o_one_hz_pin, o_fast_clock_pin})
  endtask
  task automatic t_regs();
    logic [31:0] r;
    `CHK("run_rst", 1'b0, o_counter_run)
    rd_chk("ctrl0_rst", A_C0, 8'h00);
    pins(8'h70, 1'b1, 1'b1);
    pins(8'h20, 1'b1, 1'b0);
    pins(8'h50, 1'b0, 1'b1);
    pins(8'h00, 1'b0, 1'b0);
    wr(A_C1, 8'h02);
    repeat (2) @(posedge i_clk);
    `CHK("alt_en", 1'b1, o_alt_clk_out_en)
    wr(A_C1, 8'h00);
    wr(A_BAD, 8'hFF);
    rd_chk("unmapped", A_BAD, 8'h00);
    bus(1'b1, A_C0, 32'h00000080, 4'hE, r);
    rd_chk("no_byte0", A_C0, 8'h00);
  endtask
  // hour rewritten in the new system when the format flips
  task automatic fmt(input logic [7:0] h, input logic [7:0] c, input logic [7:0] e);
    wr(A_HR, h);
    wr(A_C0, c);
    rd_chk("hour_conv", A_HR, e);
    `CHK("fmt_sel", c[3], o_hour_format_sel)
  endtask
  task automatic t_format();
    wr(A_C1, 8'h01);
    repeat (2) @(posedge i_clk);
    `CHK("hold_req", 1'b1, o_count_hold_request)
    fmt(8'h32, 8'h08, 8'h12);
    fmt(8'h13, 8'h00, 8'h21);
    fmt(8'h12, 8'h08, 8'h00);
    fmt(8'h00, 8'h00, 8'h12);
    fmt(8'h31, 8'h08, 8'h23);
    wr(A_C1, 8'h00);
    `CHK("hour_out", 6'h23, o_hour)
  endtask
  task automatic load(input logic [5:0] v, input logic [5:0] e);
    @(posedge i_clk);
    i_hour_load <= 1'b1;
    i_hour_next <= v;
    @(posedge i_clk);
    i_hour_load <= 1'b0;
    repeat (2) @(posedge i_clk);
    `CHK("hour_load", e, o_hour)
  endtask
  // mask, reselect, clear, unmask, then one tick from the chain
  task automatic ev(input logic [7:0] c, input logic h, input logic st, input logic [6:0] s,
      input logic [6:0] m, input logic [5:0] d, input logic en, input logic e);
    int p0;
    wr(A_EN, 8'h00);
    wr(A_C0, c);
    wr(A_ST, 8'h01);
    wr(A_EN, {7'h00, en});
    p0 = pulses;
    @(posedge i_clk);
    i_half_tick <= h;
    i_sec_tick <= st;
    i_sec <= s;
    i_min <= m;
    i_day <= d;
    @(posedge i_clk);
    i_half_tick <= 1'b0;
    i_sec_tick <= 1'b0;
    repeat (6) @(posedge i_clk);
    rd_chk("flag", A_ST, {7'h00, e});
    `CHK("pulses", e ? 1 : 0, pulses - p0)
    `CHK("irq", e & en, o_irq)
    wr(A_ST, 8'h01);
    rd_chk("flag_clr", A_ST, 8'h00);
    `CHK("irq_clr", 1'b0, o_irq)
  endtask
  task automatic t_events();
    load(6'h05, 6'h23);
    wr(A_C0, 8'h88);
    repeat (2) @(posedge i_clk);
    `CHK("run", 1'b1, o_counter_run)
    load(6'h00, 6'h00);
    ev(8'h88, 1'b1, 1'b1, 7'h00, 7'h00, 6'h01, 1'b1, 1'b0);
    ev(8'h89, 1'b1, 1'b0, 7'h05, 7'h05, 6'h05, 1'b1, 1'b1);
    ev(8'h8A, 1'b0, 1'b1, 7'h05, 7'h05, 6'h05, 1'b1, 1'b1);
    ev(8'h8B, 1'b0, 1'b1, 7'h00, 7'h05, 6'h05, 1'b1, 1'b1);
    ev(8'h8B, 1'b0, 1'b1, 7'h01, 7'h00, 6'h01, 1'b1, 1'b0);
    ev(8'h8C, 1'b0, 1'b1, 7'h00, 7'h00, 6'h05, 1'b1, 1'b1);
    ev(8'h8C, 1'b0, 1'b1, 7'h00, 7'h01, 6'h01, 1'b1, 1'b0);
    ev(8'h8D, 1'b0, 1'b1, 7'h00, 7'h00, 6'h05, 1'b1, 1'b1);
    ev(8'h8E, 1'b0, 1'b1, 7'h00, 7'h00, 6'h01, 1'b1, 1'b1);
    ev(8'h8F, 1'b0, 1'b1, 7'h00, 7'h00, 6'h01, 1'b1, 1'b1);
    ev(8'h8F, 1'b0, 1'b1, 7'h00, 7'h00, 6'h02, 1'b1, 1'b0);
    ev(8'h8A, 1'b0, 1'b1, 7'h05, 7'h05, 6'h05, 1'b0, 1'b1);
    ev(8'h0A, 1'b0, 1'b1, 7'h05, 7'h05, 6'h05, 1'b1, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_regs();
    t_format();
    t_events();
    summarize();
  end
endmodule
`default_nettype wire
